/* File: kdc_device.sv */
// Display controller end: serial receiver, key scan and display state
`timescale 1ns/1ps
module kdc_device #(
    parameter int OSC_DIV = kdc_pkg::OSC_DIV_DEF,
    parameter int AGREE_T = kdc_pkg::SCAN_AGREE_T,
    parameter int RETRY_T = kdc_pkg::SCAN_RETRY_T
)(
    input wire logic core_clk_in,
    input wire logic rst_in,
    kdc_link_if.dev link,
    input wire logic ext_clk_mode_in,
    input wire logic ext_osc_in,
    input wire logic [kdc_pkg::KEY_W-1:0] key_matrix_in,
    input wire logic [kdc_pkg::DIG_AW-1:0] digit_sel_in,
    output logic display_on_out,
    output logic sleep_out,
    output logic [1:0] duty_out,
    output logic [kdc_pkg::DIGITS-1:0] digit_lit_out,
    output logic [kdc_pkg::CODE_W-1:0] char_code_out,
    output logic [kdc_pkg::ACC_AW-1:0] acc_addr_out,
    output logic key_ready_out
);
    logic [4:0] pins_s;
    logic [kdc_pkg::KEY_W-1:0] keys_s;
    logic s_ce;
    logic s_cl;
    logic s_di;
    logic s_osc;
    logic s_ext;

    kdc_sync #(.W(5), .RST_VAL(1'b0)) u_pin_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in({ext_clk_mode_in, ext_osc_in, link.di, link.cl, link.ce}),
        .sync_out(pins_s)
    );
    kdc_sync #(.W(kdc_pkg::KEY_W), .RST_VAL(1'b0)) u_key_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(key_matrix_in),
        .sync_out(keys_s)
    );
    assign s_ce = pins_s[0];
    assign s_cl = pins_s[1];
    assign s_di = pins_s[2];
    assign s_osc = pins_s[3];
    assign s_ext = pins_s[4];

    // Serial receive and key data transmit
    logic cl_d_reg, cl_d_next;
    logic ce_d_reg, ce_d_next;
    logic [kdc_pkg::SH_W-1:0] sh_reg, sh_next;
    logic [kdc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [kdc_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [kdc_pkg::RD_W-1:0] tx_reg, tx_next;
    logic do_oe_reg, do_oe_next;
    logic exec;
    logic read_done;

    // Key scan
    kdc_pkg::kdc_scan_e scan_reg, scan_next;
    logic [kdc_pkg::SCAN_CW-1:0] tcnt_reg, tcnt_next;
    logic [kdc_pkg::DIV_W-1:0] div_reg, div_next;
    logic osc_d_reg, osc_d_next;
    logic [kdc_pkg::KEY_W-1:0] snap_reg, snap_next;
    logic [kdc_pkg::KEY_W-1:0] kd_reg, kd_next;
    logic ready_reg, ready_next;
    logic tick;

    // Display state
    logic [kdc_pkg::CHAR_AW-1:0] ac_reg, ac_next;
    logic [kdc_pkg::ACC_AW-1:0] acc_reg, acc_next;
    logic [kdc_pkg::DIGITS-1:0] digen_reg, digen_next;
    logic on_reg, on_next;
    logic sleep_reg, sleep_next;
    logic [1:0] duty_reg, duty_next;
    logic [kdc_pkg::CHAR_AW-1:0] shift_reg, shift_next;
    logic [kdc_pkg::CODE_W-1:0] code_reg, code_next;
    logic [kdc_pkg::DIGITS-1:0] lit_reg, lit_next;
    logic [kdc_pkg::CODE_W-1:0] ram [2**kdc_pkg::CHAR_AW];
    logic ram_we;
    logic [kdc_pkg::INSTR_W-1:0] instr;
    logic [kdc_pkg::OP_W-1:0] op;

    always_comb
    begin
        cl_d_next = s_cl;
        ce_d_next = s_ce;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        tx_next = tx_reg;
        exec = 1'b0;
        read_done = 1'b0;
        if (s_cl && !cl_d_reg)
        begin
            sh_next = {s_di, sh_reg[kdc_pkg::SH_W-1:1]};
            cnt_next = cnt_reg + 6'h01;
            if (s_ce && addr_reg == kdc_pkg::KEY_ADDR)
                tx_next = tx_reg >> 1;
        end
        if (s_ce && !ce_d_reg)
        begin
            addr_next = sh_reg[kdc_pkg::SH_W-1 -: kdc_pkg::ADDR_W];
            cnt_next = '0;
            tx_next = {sleep_reg, kd_reg};
        end
        if (!s_ce && ce_d_reg)
        begin
            cnt_next = '0;
            addr_next = '0;
            exec = addr_reg == kdc_pkg::WR_ADDR && cnt_reg == kdc_pkg::CNT_W'(kdc_pkg::INSTR_W);
            read_done = addr_reg == kdc_pkg::KEY_ADDR;
        end
        if (s_ce)
            do_oe_next = addr_next == kdc_pkg::KEY_ADDR && !tx_next[0];
        else
            do_oe_next = ready_reg && !read_done;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cl_d_reg <= 1'b0;
            ce_d_reg <= 1'b0;
            sh_reg <= '0;
            cnt_reg <= '0;
            addr_reg <= '0;
            tx_reg <= '0;
            do_oe_reg <= 1'b0;
        end
        else
        begin
            cl_d_reg <= cl_d_next;
            ce_d_reg <= ce_d_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            tx_reg <= tx_next;
            do_oe_reg <= do_oe_next;
        end
    end
    assign link.do_out = 1'b0;
    assign link.do_oe = do_oe_reg;

    always_comb
    begin
        osc_d_next = s_osc;
        div_next = (div_reg == kdc_pkg::DIV_W'(OSC_DIV - 1)) ? '0 : div_reg + 16'h0001;
        // One period per OSC_DIV core clock cycles or external clock rising edge
        tick = s_ext ? (s_osc && !osc_d_reg) : (div_reg == kdc_pkg::DIV_W'(OSC_DIV - 1));
        scan_next = scan_reg;
        tcnt_next = tcnt_reg;
        snap_next = snap_reg;
        kd_next = kd_reg;
        ready_next = ready_reg && !read_done;
        unique case (scan_reg)
            kdc_pkg::SC_IDLE:
            begin
                if (|keys_s)
                begin
                    scan_next = kdc_pkg::SC_RUN;
                    tcnt_next = '0;
                    snap_next = keys_s;
                end
            end
            kdc_pkg::SC_RUN:
            begin
                if (tick)
                begin
                    tcnt_next = tcnt_reg + 14'h0001;
                    if (tcnt_next == kdc_pkg::SCAN_CW'(AGREE_T) && keys_s == snap_reg)
                    begin
                        kd_next = keys_s;
                        ready_next = 1'b1;
                        scan_next = kdc_pkg::SC_HOLD;
                    end
                    else if (tcnt_next == kdc_pkg::SCAN_CW'(AGREE_T))
                        snap_next = keys_s;
                    else if (tcnt_next == kdc_pkg::SCAN_CW'(RETRY_T))
                    begin
                        kd_next = keys_s;
                        ready_next = 1'b1;
                        scan_next = kdc_pkg::SC_HOLD;
                    end
                end
            end
            kdc_pkg::SC_HOLD:
            begin
                if (read_done)
                    scan_next = kdc_pkg::SC_IDLE;
            end
            default:
                scan_next = kdc_pkg::SC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            osc_d_reg <= 1'b0;
            div_reg <= '0;
            scan_reg <= kdc_pkg::SC_IDLE;
            tcnt_reg <= '0;
            snap_reg <= '0;
            kd_reg <= '0;
            ready_reg <= 1'b0;
        end
        else
        begin
            osc_d_reg <= osc_d_next;
            div_reg <= div_next;
            scan_reg <= scan_next;
            tcnt_reg <= tcnt_next;
            snap_reg <= snap_next;
            kd_reg <= kd_next;
            ready_reg <= ready_next;
        end
    end

    assign instr = sh_reg[kdc_pkg::SH_W-1 -: kdc_pkg::INSTR_W];
    assign op = instr[kdc_pkg::INSTR_W-1 -: kdc_pkg::OP_W];

    always_comb
    begin
        ac_next = ac_reg;
        acc_next = acc_reg;
        digen_next = digen_reg;
        on_next = on_reg;
        sleep_next = sleep_reg;
        duty_next = duty_reg;
        shift_next = shift_reg;
        ram_we = 1'b0;
        if (exec)
        begin
            case (op)
                kdc_pkg::OP_TECH:
                    duty_next = instr[kdc_pkg::DUTY_LSB +: 2];
                kdc_pkg::OP_CHAR:
                begin
                    ram_we = 1'b1;
                    ac_next = ac_reg + 6'h01;
                end
                kdc_pkg::OP_SETAC:
                begin
                    ac_next = instr[kdc_pkg::CHAR_AW-1:0];
                    acc_next = instr[kdc_pkg::ACC_LSB +: kdc_pkg::ACC_AW];
                end
                kdc_pkg::OP_DISP:
                begin
                    digen_next = instr[kdc_pkg::DIGITS-1:0];
                    on_next = instr[kdc_pkg::ON_BIT];
                    sleep_next = instr[kdc_pkg::SLEEP_BIT];
                end
                kdc_pkg::OP_SHIFT:
                begin
                    if (instr[kdc_pkg::SHIFT_BIT])
                        shift_next = shift_reg + 6'h01;
                end
                default:
                    ac_next = ac_reg;
            endcase
        end
        // Sleep or display off blanks every digit
        lit_next = digen_reg & {kdc_pkg::DIGITS{on_reg && !sleep_reg}};
        code_next = ram[shift_reg + kdc_pkg::CHAR_AW'(digit_sel_in)];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            ac_reg <= '0;
            acc_reg <= '0;
            digen_reg <= '0;
            on_reg <= 1'b0;
            sleep_reg <= 1'b0;
            duty_reg <= '0;
            shift_reg <= '0;
            code_reg <= '0;
            lit_reg <= '0;
        end
        else
        begin
            ac_reg <= ac_next;
            acc_reg <= acc_next;
            digen_reg <= digen_next;
            on_reg <= on_next;
            sleep_reg <= sleep_next;
            duty_reg <= duty_next;
            shift_reg <= shift_next;
            code_reg <= code_next;
            lit_reg <= lit_next;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (ram_we)
            ram[ac_reg] <= instr[kdc_pkg::CODE_W-1:0];
    end

    assign display_on_out = on_reg;
    assign sleep_out = sleep_reg;
    assign duty_out = duty_reg;
    assign digit_lit_out = lit_reg;
    assign char_code_out = code_reg;
    assign acc_addr_out = acc_reg;
    assign key_ready_out = ready_reg;
endmodule // kdc_device

/* File: kdc_host.sv */
// Host controller end: command writer and key data poller
`timescale 1ns/1ps
module kdc_host #(
    parameter int HALF = kdc_pkg::HALF_DEF,
    parameter int POLL = kdc_pkg::POLL_CYC_DEF,
    parameter int HOLDOFF = kdc_pkg::HOLDOFF_DEF
)(
    input wire logic core_clk_in,
    input wire logic rst_in,
    kdc_link_if.host link,
    input wire logic int_mode_in,
    input wire logic cmd_valid_in,
    input wire logic [kdc_pkg::INSTR_W-1:0] cmd_word_in,
    output logic cmd_ready_out,
    output logic key_valid_out,
    output logic [kdc_pkg::KEY_W-1:0] key_data_out,
    output logic sleep_ack_out
);
    logic s_do;
    kdc_sync #(.W(1), .RST_VAL(1'b1)) u_do_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in(link.do_line),
        .sync_out(s_do)
    );

    kdc_pkg::kdc_host_e st_reg, st_next;
    logic [kdc_pkg::PH_W-1:0] ph_reg, ph_next;
    logic [kdc_pkg::CNT_W-1:0] bit_reg, bit_next;
    logic [kdc_pkg::SH_W-1:0] sh_reg, sh_next;
    logic [kdc_pkg::RD_W-1:0] rx_reg, rx_next;
    logic [kdc_pkg::TMR_W-1:0] tmr_reg, tmr_next;
    logic [kdc_pkg::KEY_W-1:0] kd_reg, kd_next;
    logic hi_reg, hi_next;
    logic ce_reg, ce_next;
    logic di_reg, di_next;
    logic rd_reg, rd_next;
    logic ok_reg, ok_next;
    logic kv_reg, kv_next;
    logic sa_reg, sa_next;
    logic due;
    logic start_rd;
    logic [kdc_pkg::CNT_W-1:0] last_bit;

    assign due = tmr_reg == '0;
    // Key read only starts while data-out is low with CE low
    assign start_rd = st_reg == kdc_pkg::H_IDLE && due && !s_do;
    assign cmd_ready_out = st_reg == kdc_pkg::H_IDLE && !start_rd;
    assign last_bit = rd_reg ? kdc_pkg::CNT_W'(kdc_pkg::RD_W - 1)
                             : kdc_pkg::CNT_W'(kdc_pkg::INSTR_W - 1);

    always_comb
    begin
        st_next = st_reg;
        ph_next = ph_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        tmr_next = due ? tmr_reg : tmr_reg - 20'h00001;
        kd_next = kd_reg;
        hi_next = hi_reg;
        ce_next = ce_reg;
        di_next = di_reg;
        rd_next = rd_reg;
        ok_next = ok_reg;
        kv_next = 1'b0;
        sa_next = sa_reg;
        unique case (st_reg)
            kdc_pkg::H_IDLE:
            begin
                if (due && !int_mode_in)
                    tmr_next = kdc_pkg::TMR_W'(POLL);
                if (start_rd || cmd_valid_in)
                begin
                    rd_next = start_rd;
                    ok_next = !s_do;
                    if (start_rd)
                        sh_next = {24'h000000, kdc_pkg::KEY_ADDR};
                    else
                        sh_next = {cmd_word_in, kdc_pkg::WR_ADDR};
                    di_next = sh_next[0];
                    st_next = kdc_pkg::H_ADDR;
                    ph_next = '0;
                    bit_next = '0;
                    hi_next = 1'b0;
                end
            end
            kdc_pkg::H_ADDR, kdc_pkg::H_DATA:
            begin
                ph_next = ph_reg + 8'h01;
                if (ph_reg == kdc_pkg::PH_W'(HALF - 1))
                begin
                    ph_next = '0;
                    hi_next = !hi_reg;
                    if (!hi_reg)
                        rx_next = {s_do, rx_reg[kdc_pkg::RD_W-1:1]};
                    else
                    begin
                        sh_next = sh_reg >> 1;
                        di_next = sh_reg[1];
                        bit_next = bit_reg + 6'h01;
                        if (st_reg == kdc_pkg::H_ADDR &&
                            bit_reg == kdc_pkg::CNT_W'(kdc_pkg::ADDR_W - 1))
                        begin
                            st_next = kdc_pkg::H_DATA;
                            ce_next = 1'b1;
                            bit_next = '0;
                        end
                        else if (st_reg == kdc_pkg::H_DATA && bit_reg == last_bit)
                        begin
                            st_next = kdc_pkg::H_END;
                            ce_next = 1'b0;
                        end
                    end
                end
            end
            kdc_pkg::H_END:
            begin
                ph_next = ph_reg + 8'h01;
                if (ph_reg == kdc_pkg::PH_W'(HALF - 1))
                begin
                    st_next = kdc_pkg::H_IDLE;
                    if (rd_reg)
                    begin
                        kv_next = ok_reg;
                        kd_next = rx_reg[kdc_pkg::KEY_W-1:0];
                        sa_next = rx_reg[kdc_pkg::RD_W-1];
                        if (int_mode_in)
                            tmr_next = kdc_pkg::TMR_W'(HOLDOFF);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            st_reg <= kdc_pkg::H_IDLE;
            ph_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '0;
            rx_reg <= '0;
            tmr_reg <= '0;
            kd_reg <= '0;
            hi_reg <= 1'b0;
            ce_reg <= 1'b0;
            di_reg <= 1'b0;
            rd_reg <= 1'b0;
            ok_reg <= 1'b0;
            kv_reg <= 1'b0;
            sa_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            ph_reg <= ph_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            tmr_reg <= tmr_next;
            kd_reg <= kd_next;
            hi_reg <= hi_next;
            ce_reg <= ce_next;
            di_reg <= di_next;
            rd_reg <= rd_next;
            ok_reg <= ok_next;
            kv_reg <= kv_next;
            sa_reg <= sa_next;
        end
    end

    assign link.ce = ce_reg;
    assign link.cl = hi_reg;
    assign link.di = di_reg;
    assign key_valid_out = kv_reg;
    assign key_data_out = kd_reg;
    assign sleep_ack_out = sa_reg;
endmodule // kdc_host

/* File: kdc_link_if.sv */
// Three-wire serial link with open-drain data-out
`timescale 1ns/1ps
interface kdc_link_if;
    logic ce;
    logic cl;
    logic di;
    logic do_out;
    logic do_oe;
    logic do_line;
    // Pull-up holds the line high unless the device drives it
    assign do_line = do_oe ? do_out : 1'b1;
    modport dev (input ce, input cl, input di, input do_line, output do_out, output do_oe);
    modport host (output ce, output cl, output di, input do_line);
endinterface

/* File: kdc_pkg.sv */
// Shared constants for the key read and display command link
// Contract
// - Agreeing scans report after 4800 periods
// - Disagreeing scans rescan, 9600 periods total
// - Host sends address 43h, then reads keys
// - Data-out low with CE low means key
// - Timer poll period exceeds retry plus read
// - Read with data-out high gives invalid keys
// - Interrupt mode waits beyond retry scan time
// - Technique code 0,8 selects 1/8 duty
// - Character write stores, then address increments
// - Set-address loads character and accessory address
// - All digit enables light 16 digits
// - Shift moves main display left only
// - Sleep bit blanks all digits
// - Display stays off after reset
package kdc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] WR_ADDR = 8'h41;
    localparam logic [7:0] KEY_ADDR = 8'h43;
    localparam int INSTR_W = 24;
    localparam int KEY_W = 30;
    localparam int RD_W = 31;
    localparam int SH_W = 32;
    localparam int CNT_W = 6;
    localparam int OP_W = 4;
    localparam logic [3:0] OP_TECH = 4'h8;
    localparam logic [3:0] OP_CHAR = 4'ha;
    localparam logic [3:0] OP_SETAC = 4'h2;
    localparam logic [3:0] OP_DISP = 4'h4;
    localparam logic [3:0] OP_SHIFT = 4'hc;
    localparam int ON_BIT = 16;
    localparam int SLEEP_BIT = 19;
    localparam int SHIFT_BIT = 16;
    localparam int DUTY_LSB = 16;
    localparam int ACC_LSB = 8;
    localparam int CHAR_AW = 6;
    localparam int ACC_AW = 4;
    localparam int CODE_W = 8;
    localparam int DIGITS = 16;
    localparam int DIG_AW = 4;
    localparam int SCAN_AGREE_T = 4800;
    localparam int SCAN_RETRY_T = 9600;
    localparam int SCAN_CW = 14;
    localparam int DIV_W = 16;
    localparam int OSC_DIV_DEF = 16;
    localparam int HALF_DEF = 8;
    localparam int PH_W = 8;
    localparam int TMR_W = 20;
    localparam int FRAME_CYC = 2 * HALF_DEF * (ADDR_W + RD_W + 2);
    localparam int RETRY_CYC_DEF = SCAN_RETRY_T * OSC_DIV_DEF;
    localparam int POLL_CYC_DEF = RETRY_CYC_DEF + FRAME_CYC + HALF_DEF;
    localparam int HOLDOFF_DEF = RETRY_CYC_DEF + HALF_DEF;
    typedef enum logic [1:0] {SC_IDLE = 2'b00, SC_RUN = 2'b01, SC_HOLD = 2'b10} kdc_scan_e;
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_ADDR = 2'b01, H_DATA = 2'b10, H_END = 2'b11}
        kdc_host_e;
endpackage

/* File: kdc_props.sv */
// Link protocol checker for the three-wire key and display link
`timescale 1ns/1ps
module kdc_props (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce,
    input wire logic cl,
    input wire logic di,
    input wire logic do_out,
    input wire logic do_oe,
    input wire logic do_line
);
    logic [5:0] addr_cnt_reg;
    logic [5:0] addr_cnt_next;
    logic [5:0] data_cnt_reg;
    logic [5:0] data_cnt_next;
    logic cl_prev_reg;
    // Count clock rises in the address and data phases
    always_comb
    begin
        addr_cnt_next = ce ? 6'h00 : addr_cnt_reg + {5'h00, cl & ~cl_prev_reg};
        data_cnt_next = !ce ? 6'h00 : data_cnt_reg + {5'h00, cl & ~cl_prev_reg};
    end
    always_ff @(posedge core_clk_in)
    begin
        addr_cnt_reg <= rst_in ? 6'h00 : addr_cnt_next;
        data_cnt_reg <= rst_in ? 6'h00 : data_cnt_next;
        cl_prev_reg <= rst_in ? 1'b0 : cl;
    end
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_cl_high;
        cl [*8] ##1 !cl;
    endsequence
    sequence s_tail_low;
        !cl [*8];
    endsequence
    a_do_pulls_low: assert property (do_oe |-> !do_out && !do_line)
        else $error("data-out driven but not low");
    a_line_pulled_up: assert property (!do_oe |-> do_line)
        else $error("released data-out not high");
    a_reset_quiet_link: assert property ($fell(rst_in) |-> !do_oe && !ce && !cl)
        else $error("link not idle after reset");
    a_cl_high_stands: assert property ($rose(cl) |-> s_cl_high)
        else $error("clock high phase wrong length");
    a_di_holds_high: assert property (cl |-> $stable(di))
        else $error("data changed while clock high");
    a_addr_eight_bits: assert property ($rose(ce) |-> addr_cnt_reg == 6'h08)
        else $error("address phase not eight bits");
    a_data_bit_count: assert property ($fell(ce) |-> data_cnt_reg inside {6'h18, 6'h1f})
        else $error("data phase bit count wrong");
    a_ce_tail_quiet: assert property ($fell(ce) |-> s_tail_low)
        else $error("clock moved after frame end");
endmodule // kdc_props

/* File: kdc_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module kdc_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
)(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            meta_reg <= {W{RST_VAL}};
            sync_reg <= {W{RST_VAL}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule // kdc_sync

/* File: key_read_and_display_cmds_tb_top.sv */
// Self-checking bench joining the host and device ends over the link
`timescale 1ns/1ps
module key_read_and_display_cmds_tb_top;
    localparam int POLL_T = 2000;
    localparam int HOLD_T = 300;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic int_mode = 1'b0;
    logic cmd_valid = 1'b0;
    logic [23:0] cmd_word = 24'h000000;
    logic [29:0] keys = 30'h00000000;
    logic [3:0] digit_sel = 4'h0;
    logic ext_mode = 1'b0;
    logic ext_osc = 1'b0;
    logic cmd_ready, key_valid, sleep_ack, display_on, sleep_st, key_ready;
    logic [29:0] key_data;
    logic [1:0] duty;
    logic [15:0] lit;
    logic [7:0] code;
    logic [3:0] acc;
    int num_errors = 0;
    int checks = 0;
    int gap;
    kdc_link_if link ();
    kdc_device #(.OSC_DIV(1), .AGREE_T(4), .RETRY_T(8)) u_kdc_device (
        .core_clk_in(core_clk), .rst_in(rst), .link(link), .ext_clk_mode_in(ext_mode),
        .ext_osc_in(ext_osc), .key_matrix_in(keys), .digit_sel_in(digit_sel),
        .display_on_out(display_on), .sleep_out(sleep_st), .duty_out(duty),
        .digit_lit_out(lit), .char_code_out(code), .acc_addr_out(acc),
        .key_ready_out(key_ready));
    kdc_host #(.HALF(8), .POLL(POLL_T), .HOLDOFF(HOLD_T)) u_kdc_host (
        .core_clk_in(core_clk), .rst_in(rst), .link(link), .int_mode_in(int_mode),
        .cmd_valid_in(cmd_valid), .cmd_word_in(cmd_word), .cmd_ready_out(cmd_ready),
        .key_valid_out(key_valid), .key_data_out(key_data), .sleep_ack_out(sleep_ack));
    kdc_props u_kdc_props (.core_clk_in(core_clk), .rst_in(rst), .ce(link.ce),
        .cl(link.cl), .di(link.di), .do_out(link.do_out), .do_oe(link.do_oe),
        .do_line(link.do_line));
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Present one instruction, then wait for the frame and its effect
    task automatic send(input logic [23:0] w);
        int n;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        @(negedge core_clk);
        for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++)
            @(negedge core_clk);
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        @(negedge core_clk);
        for (n = 0; n < 2000 && cmd_ready !== 1'b1; n++)
            @(negedge core_clk);
        repeat (8) @(negedge core_clk);
    endtask
    // Cycles until the next key data pulse
    task automatic wait_key(output int n);
        @(negedge core_clk);
        for (n = 0; n < 5000 && key_valid !== 1'b1; n++)
            @(negedge core_clk);
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk(32'(display_on), 32'h0);
        chk(32'(lit), 32'h0);
        // External clock mode: scan periods only advance on oscillator edges
        @(posedge core_clk);
        ext_mode <= 1'b1;
        keys <= 30'h00000003;
        for (int i = 0; i < 4; i++)
        begin
            repeat (8) @(negedge core_clk);
            chk(32'(key_ready), 32'h0);
            @(posedge core_clk);
            ext_osc <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_osc <= 1'b0;
        end
        repeat (8) @(negedge core_clk);
        chk(32'(key_ready), 32'h1);
        @(posedge core_clk);
        ext_mode <= 1'b0;
        keys <= 30'h00000000;
        send(24'h810000);
        chk(32'(duty), 32'h1);
        send(24'h800000);
        chk(32'(duty), 32'h0);
        send(24'h200305);
        chk(32'(acc), 32'h3);
        send(24'h200000);
        chk(32'(acc), 32'h0);
        for (int i = 0; i < 4; i++)
            send(24'ha00041 + 24'(i));
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            digit_sel <= 4'(i);
            repeat (4) @(negedge core_clk);
            chk(32'(code), 32'h41 + 32'(i));
        end
        @(posedge core_clk);
        digit_sel <= 4'h0;
        send(24'h41ffff);
        chk(32'(display_on), 32'h1);
        chk(32'(lit), 32'hffff);
        send(24'hc10000);
        chk(32'(code), 32'h42);
        chk(32'(acc), 32'h0);
        send(24'h480000);
        chk(32'(sleep_st), 32'h1);
        chk(32'(lit), 32'h0);
        send(24'h41ffff);
        chk(32'(lit), 32'hffff);
        @(posedge core_clk);
        keys <= 30'h20000001;
        wait_key(gap);
        chk(32'(key_data), 32'h20000001);
        chk(32'(sleep_ack), 32'h0);
        wait_key(gap);
        chk(32'(gap <= POLL_T + 700), 32'h1);
        @(posedge core_clk);
        keys <= 30'h00000000;
        repeat (POLL_T + 700) @(negedge core_clk);
        @(posedge core_clk);
        keys <= 30'h0aaa5555;
        repeat (3) @(posedge core_clk);
        keys <= 30'h15550aaa;
        // Past the agreeing scan time a disagreeing scan must still be running
        repeat (6) @(negedge core_clk);
        chk(32'(key_ready), 32'h0);
        wait_key(gap);
        chk(32'(key_data), 32'h15550aaa);
        @(posedge core_clk);
        int_mode <= 1'b1;
        keys <= 30'h3fffffff;
        wait_key(gap);
        wait_key(gap);
        chk(32'(key_data), 32'h3fffffff);
        chk(32'(gap > HOLD_T + 600), 32'h1);
        send(24'h480000);
        wait_key(gap);
        chk(32'(sleep_ack), 32'h1);
        report_and_stop();
    end
endmodule // key_read_and_display_cmds_tb_top
